// ==== testbench/pms_host_model.sv ====
// pms_host_model: host side that drives the two power enable pins.
// assumes: bench commands; pins move just after pclk rising edges.
`timescale 1ns/1ps
module pms_host_model (
	input  wire logic pclk,
	input  wire logic wl_cmd,
	input  wire logic bt_cmd,
	output logic      wl_pin,
	output logic      bt_pin
);
	// pins are low until the host asks; pull-downs would agree
	initial begin
		wl_pin = 1'b0;
		bt_pin = 1'b0;
	end
	// only the host brings the regulators back after shutdown
	always @(posedge pclk) begin
		wl_pin <= wl_cmd;
		bt_pin <= bt_cmd;
	end
endmodule

// ==== testbench/pms_sequencer_tb_top.sv ====
// pms_sequencer_tb_top: self-checking bench for the resource sequencer.
// assumes: pms_pkg compiled first; crystal ticks come only in the
// calibration test, at the default slow period.
`timescale 1ns/1ps
module pms_sequencer_tb_top;
	localparam int D = pms_pkg::SLOW_DIV;
	logic                     pclk;
	logic                     presetn;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [11:0]              paddr;
	logic [31:0]              pwdata;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     wl_cmd;
	logic                     bt_cmd;
	logic                     wl;
	logic                     bt;
	logic [3:0]               creq;
	pms_pkg::pms_in_type      pins;
	pms_pkg::pms_out_type     ctl;
	logic [7:0]               on_f;
	logic [31:0]              rd;
	logic                     er;
	logic                     xtal;
	int                       n_mismatch;
	int                       compares;
	int                       n;
	// irq and resume stay low: deep sleep wakes by request timer
	assign pins = {wl, bt, 1'b0, 1'b0, creq};
	pms_sequencer pms_sequencer_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .xtal_tick(xtal), .ctl(ctl),
		.resource_on_flag(on_f));
	pms_host_model pms_host_model_i (.pclk(pclk), .wl_cmd(wl_cmd),
		.bt_cmd(bt_cmd), .wl_pin(wl), .bt_pin(bt));
	// free-running 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic test_done;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			$display("Error pready expected 1 seen %b", pready);
			test_done();
		end
	endtask
	// bounded wait for a settled resource pattern
	task automatic wait_on(input logic [7:0] e, output int k);
		for (k = 0; k < 8 * D; k++) begin
			@(posedge pclk);
			if (on_f === e) return;
		end
		n_mismatch++;
		$display("Error on flags expected %h seen %h", e, on_f);
		test_done();
	endtask
	task automatic t_reset;
		chk("pd_wlan_en", 1, ctl.pd_wlan_en);
		chk("pd_bt_en", 1, ctl.pd_bt_en);
		chk("reg_en", 0, ctl.reg_en);
		chk("outs_oe", 0, ctl.outs_oe);
		wl_cmd <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("reg_en", 1, ctl.reg_en);
		chk("wlan_rst_n", 1, ctl.wlan_rst_n);
		apb(1'b0, pms_pkg::A_MIN, 0);
		chk("min", 32'h01, rd);
		$display("test reset done");
	endtask
	task automatic t_seq;
		apb(1'b1, pms_pkg::A_TON, 0);
		wait_on(8'h01, n);
		apb(1'b1, pms_pkg::A_TON + 12'h004, 3);
		apb(1'b1, pms_pkg::A_TOFF + 12'h004, 0);
		apb(1'b1, pms_pkg::A_MIN, 32'h03);
		repeat (D * 5 / 2) @(posedge pclk);
		apb(1'b0, pms_pkg::A_PEND, 0);
		chk("pending", 32'h02, rd);
		wait_on(8'h03, n);
		chk("on delay", 1, D * 5 / 2 + n >= 3 * D);
		chk("on delay max", 1, D * 5 / 2 + n < 6 * D);
		apb(1'b0, pms_pkg::A_PEND, 0);
		chk("pending", 0, rd);
		apb(1'b0, pms_pkg::A_STATE, 0);
		chk("state", 32'h03, {24'h0, rd[7:0]});
		apb(1'b1, pms_pkg::A_MIN, 32'h01);
		wait_on(8'h01, n);
		chk("off fast", 1, n < 3 * D);
		$display("test sequence done");
	endtask
	task automatic t_dep;
		apb(1'b1, pms_pkg::A_TON + 12'h008, 0);
		apb(1'b1, pms_pkg::A_TON + 12'h00C, 0);
		apb(1'b1, pms_pkg::A_TOFF + 12'h008, 0);
		apb(1'b1, pms_pkg::A_TOFF + 12'h00C, 0);
		apb(1'b1, pms_pkg::A_DEP + 12'h008, 32'h08);
		apb(1'b1, pms_pkg::A_CMAP, 32'h04);
		creq <= 4'h1;
		wait_on(8'h0D, n);
		creq <= 4'h0;
		wait_on(8'h01, n);
		$display("test dependency done");
	endtask
	task automatic t_ctl;
		apb(1'b1, pms_pkg::A_CTRL, 32'h07);
		repeat (3) @(posedge pclk);
		chk("pd_wlan_en", 0, ctl.pd_wlan_en);
		chk("ldo_bypass", 0, ctl.ldo_bypass);
		chk("pll_clk_en", 0, ctl.pll_clk_en);
		chk("xtal_clk_en", 0, ctl.xtal_clk_en);
		// bypass plus deep sleep: bypass only shows once asleep
		apb(1'b1, pms_pkg::A_CTRL, 32'h0A);
		repeat (6) @(posedge pclk);
		chk("ldo_bypass", 1, ctl.ldo_bypass);
		apb(1'b0, pms_pkg::A_STATE, 0);
		chk("mode", 32'h08, {27'h0, rd[12:8]});
		// a timer request for an off resource wakes the part
		apb(1'b1, pms_pkg::A_RTMR, 32'h80);
		apb(1'b0, pms_pkg::A_CTRL, 0);
		chk("restored ctrl", 32'h02, rd);
		apb(1'b0, pms_pkg::A_STATE, 0);
		chk("mode", 32'h01, {27'h0, rd[12:8]});
		chk("ldo_bypass", 0, ctl.ldo_bypass);
		apb(1'b1, pms_pkg::A_RTMR, 0);
		apb(1'b1, pms_pkg::A_CTRL, 0);
		apb(1'b0, 12'hFFC, 0);
		chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
		$display("test control done");
	endtask
	// crystal ticks every D pclk: the trimmed period equals the default
	task automatic t_cal;
		apb(1'b1, pms_pkg::A_CTRL, 32'h20);
		repeat (3) begin
			xtal <= 1'b1;
			repeat (4) @(posedge pclk);
			xtal <= 1'b0;
			repeat (D - 4) @(posedge pclk);
		end
		apb(1'b1, pms_pkg::A_CTRL, 0);
		apb(1'b0, pms_pkg::A_CAL, 0);
		chk("cal", D - 1, rd);
		$display("test calibration done");
	endtask
	task automatic t_pins;
		// leave state behind that shutdown must forget
		apb(1'b1, pms_pkg::A_CTRL, 32'h01);
		apb(1'b1, pms_pkg::A_MIN, 32'h03);
		bt_cmd <= 1'b1;
		wl_cmd <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("reg_en", 1, ctl.reg_en);
		chk("wlan_rst_n", 0, ctl.wlan_rst_n);
		bt_cmd <= 1'b0;
		repeat (8) @(posedge pclk);
		chk("reg_en", 0, ctl.reg_en);
		chk("outs_oe", 0, ctl.outs_oe);
		chk("ins_en", 0, ctl.ins_en);
		wl_cmd <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("reg_en", 1, ctl.reg_en);
		apb(1'b0, pms_pkg::A_MIN, 0);
		chk("min", 32'h01, rd);
		apb(1'b0, pms_pkg::A_CAL, 0);
		chk("cal", 0, rd);
		chk("pd_wlan_en", 1, ctl.pd_wlan_en);
		$display("test pins done");
	endtask
	// main sequence: reset held 12 cycles, then each scenario
	initial begin
		n_mismatch = 0;
		compares = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		wl_cmd = 1'b0;
		bt_cmd = 1'b0;
		creq = 4'h0;
		xtal = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_seq();
		t_dep();
		t_ctl();
		t_cal();
		t_pins();
		test_done();
	end
endmodule

// ==== verilog/pms_pkg.sv ====
// pms_pkg: constants and carrier types for the power resource sequencer.
// assumes: one 100 MHz pclk domain, APB slave access, 32-bit data.
// Behaviour
// - each resource in one of four states
// - timer zero unless resource is mid-transition
// - load on/off delay when change decided
// - decrement per slow tick; zero ends transition
// - zero on-delay enables immediately
// - zero off-delay disables immediately
// - recompute required set every slow tick
// - at zero clear pending, toggle on flag
// - disable unrequested enabled resource without powered dependents
// - enable requested disabled resource with dependencies on
// - request is clock, minimum and timer union
// - map core clock requests to resources
// - wlan pin high releases wlan reset
// - regulator enable is OR of pins
// - pin pull-downs on after reset, software off
// - shutdown tristates outputs, disables inputs
// - leaving shutdown acts as fresh power-up
// - save state before deep sleep, restore on wake
// - doze stops main clocks, keeps slow clock
// - calibrate slow timer against crystal clock
// - core regulator bypass mode for deep sleep
package pms_pkg;
	localparam int NRES = 8;
	localparam int TW   = 8;
	localparam int NCLK = 4;
	// slow sequencer tick derived from pclk
	localparam int CLK_HZ  = 100_000_000;
	localparam int SLOW_HZ = 32_768;
	localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
	// register byte offsets
	localparam logic [11:0] A_CTRL   = 12'h000;
	localparam logic [11:0] A_MIN    = 12'h004;
	localparam logic [11:0] A_STATE  = 12'h008;
	localparam logic [11:0] A_PEND   = 12'h00C;
	localparam logic [11:0] A_RTMR   = 12'h010;
	localparam logic [11:0] A_CAL    = 12'h014;
	localparam logic [11:0] A_TON    = 12'h040;
	localparam logic [11:0] A_TOFF   = 12'h060;
	localparam logic [11:0] A_DEP    = 12'h080;
	localparam logic [11:0] A_CMAP   = 12'h0A0;
	// control bit positions
	localparam int C_PD_OFF = 0;
	localparam int C_BYPASS = 1;
	localparam int C_DOZE   = 2;
	localparam int C_DEEP   = 3;
	localparam int C_SHUT   = 4;
	localparam int C_CALGO  = 5;
	localparam logic [7:0] MIN_RST = 8'h01;
	localparam logic [7:0] WAKE_RES = 8'h01;
	typedef enum logic [4:0] {
		PM_ACTIVE = 5'b00001,
		PM_DOZE   = 5'b00010,
		PM_SAVE   = 5'b00100,
		PM_DEEP   = 5'b01000,
		PM_SHUT   = 5'b10000
	} pms_mode_type;
	typedef struct packed {
		logic wlan_pin;
		logic bt_pin;
		logic ext_irq;
		logic sdio_resume;
		logic [3:0] core_clk_req;
	} pms_in_type;
	typedef struct packed {
		logic reg_en;
		logic wlan_rst_n;
		logic pd_wlan_en;
		logic pd_bt_en;
		logic pll_clk_en;
		logic xtal_clk_en;
		logic ldo_bypass;
		logic outs_oe;
		logic ins_en;
		logic ret_save;
		logic ret_restore;
	} pms_out_type;
endpackage

// ==== verilog/pms_sequencer.sv ====
// pms_sequencer: resource sequencer with APB registers and pin handling.
// assumes: pins asynchronous to pclk; crystal tick input asynchronous.
`timescale 1ns/1ps
module pms_sequencer (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire pms_pkg::pms_in_type      pins,
	input  wire logic                     xtal_tick,
	output pms_pkg::pms_out_type          ctl,
	output logic      [pms_pkg::NRES-1:0] resource_on_flag
);
	localparam int N = pms_pkg::NRES;
	localparam int W = pms_pkg::TW;
	// all per-resource storage as vectors by index
	logic [W-1:0] ton_r   [N];
	logic [W-1:0] toff_r  [N];
	logic [W-1:0] tmr_r   [N];
	logic [N-1:0] dep_r   [N];
	logic [N-1:0] cmap_r  [pms_pkg::NCLK];
	logic [N-1:0] on_r, pend_r, min_r, rtmr_r, need_r;
	logic [7:0]   ctrl_r, save_r;
	logic [15:0]  div_r, cal_r, calcnt_r;
	logic         tick_r;
	pms_pkg::pms_mode_type mode_r;
	pms_pkg::pms_in_type   s1_r, s2_r;
	logic [2:0]   xs_r;

	// double-flop every pin before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
			xs_r <= 3'h0;
		end else begin
			s1_r <= pins;
			s2_r <= s1_r;
			xs_r <= {xs_r[1:0], xtal_tick};
		end
	end
	wire xtal_edge = xs_r[1] & ~xs_r[2];

	// slow tick: period trimmed by calibration result
	wire [15:0] div_end = (cal_r != 16'h0) ? cal_r
		: 16'(pms_pkg::SLOW_DIV - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r  <= 16'h0;
			tick_r <= 1'b0;
		end else begin
			// >= so a shorter new period cannot strand the counter
			tick_r <= (div_r >= div_end);
			div_r  <= (div_r >= div_end) ? 16'h0 : div_r + 16'h1;
		end
	end

	// calibrate: count pclk between crystal ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			calcnt_r <= 16'h0;
			cal_r    <= 16'h0;
		end else if (mode_r == pms_pkg::PM_SHUT) begin
			calcnt_r <= 16'h0; // no calibration survives shutdown
			cal_r    <= 16'h0;
		end else if (xtal_edge) begin
			calcnt_r <= 16'h0;
			if (ctrl_r[pms_pkg::C_CALGO])
				cal_r <= calcnt_r;
		end else begin
			calcnt_r <= calcnt_r + 16'h1;
		end
	end

	// request union: clocks via map, minimum mask, timer requests
	logic [N-1:0] clk_res;
	always_comb begin
		clk_res = '0;
		for (int c = 0; c < pms_pkg::NCLK; c++)
			if (s2_r.core_clk_req[c])
				clk_res = clk_res | cmap_r[c];
	end
	wire [N-1:0] req = clk_res | min_r | rtmr_r;

	// close request under dependencies (one hop per level)
	function automatic logic [N-1:0] close_deps(input logic [N-1:0] r,
		input logic [N-1:0] d [N]);
		logic [N-1:0] acc;
		acc = r;
		for (int k = 0; k < N; k++)
			for (int i = 0; i < N; i++)
				if (acc[i])
					acc = acc | d[i];
		return acc;
	endfunction
	wire [N-1:0] need_nxt = close_deps(req, dep_r);

	// per-resource step on each slow tick
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_res
			logic dep_ok, dependent_on;
			always_comb begin
				dep_ok = ((dep_r[g] & on_r & ~pend_r) == dep_r[g]);
				dependent_on = 1'b0;
				for (int j = 0; j < N; j++)
					if (dep_r[j][g] && (on_r[j] || pend_r[j]))
						dependent_on = 1'b1;
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					tmr_r[g]  <= '0;
					on_r[g]   <= 1'b0;
					pend_r[g] <= 1'b0;
				end else if (mode_r == pms_pkg::PM_SHUT) begin
					tmr_r[g]  <= '0; // shutdown forgets all
					on_r[g]   <= 1'b0;
					pend_r[g] <= 1'b0;
				end else if (tick_r) begin
					if (pend_r[g]) begin
						if (tmr_r[g] == W'(1)) begin
							pend_r[g] <= 1'b0;
							on_r[g]   <= ~on_r[g];
						end
						tmr_r[g] <= tmr_r[g] - W'(1);
					end else if (!on_r[g] && need_r[g] && dep_ok) begin
						if (ton_r[g] == '0)
							on_r[g] <= 1'b1;
						else begin
							on_r[g]   <= 1'b0;
							pend_r[g] <= 1'b1;
							tmr_r[g]  <= ton_r[g];
						end
					end else if (on_r[g] && !need_r[g] && !dependent_on) begin
						if (toff_r[g] == '0)
							on_r[g] <= 1'b0;
						else begin
							pend_r[g] <= 1'b1;
							tmr_r[g]  <= toff_r[g];
						end
					end
				end
			end
		end
	endgenerate

	// required set refreshed once per slow tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			need_r <= '0;
		else if (tick_r)
			need_r <= need_nxt;
	end

	// power mode: doze, deep sleep with retention, shutdown
	wire wake = s2_r.ext_irq | s2_r.sdio_resume
		| (|(rtmr_r & ~on_r));
	wire any_pin = s2_r.wlan_pin | s2_r.bt_pin;
	pms_pkg::pms_mode_type mode_nxt;
	always_comb begin
		case (mode_r)
			pms_pkg::PM_ACTIVE:
				mode_nxt = !any_pin ? pms_pkg::PM_SHUT
					: ctrl_r[pms_pkg::C_DEEP] ? pms_pkg::PM_SAVE
					: ctrl_r[pms_pkg::C_DOZE] ? pms_pkg::PM_DOZE
					: pms_pkg::PM_ACTIVE;
			pms_pkg::PM_DOZE:
				mode_nxt = !any_pin ? pms_pkg::PM_SHUT
					: (wake || !ctrl_r[pms_pkg::C_DOZE])
					? pms_pkg::PM_ACTIVE : pms_pkg::PM_DOZE;
			pms_pkg::PM_SAVE:
				mode_nxt = pms_pkg::PM_DEEP;
			pms_pkg::PM_DEEP:
				mode_nxt = !any_pin ? pms_pkg::PM_SHUT
					: wake ? pms_pkg::PM_ACTIVE : pms_pkg::PM_DEEP;
			// only the pins bring it back
			pms_pkg::PM_SHUT:
				mode_nxt = any_pin ? pms_pkg::PM_ACTIVE : pms_pkg::PM_SHUT;
			default:
				mode_nxt = pms_pkg::PM_SHUT;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_r <= pms_pkg::PM_SHUT;
		else
			mode_r <= mode_nxt;
	end

	// APB slave: zero wait, unmapped reads zero with error
	wire wr = psel & penable & pwrite;
	wire [3:0] idx = paddr[5:2];
	wire in_ton  = (paddr[11:5] == pms_pkg::A_TON[11:5]);
	wire in_toff = (paddr[11:5] == pms_pkg::A_TOFF[11:5]);
	wire in_dep  = (paddr[11:5] == pms_pkg::A_DEP[11:5]);
	wire in_cmap = (paddr[11:4] == pms_pkg::A_CMAP[11:4]);
	wire hit_fix = (paddr == pms_pkg::A_CTRL) | (paddr == pms_pkg::A_MIN)
		| (paddr == pms_pkg::A_STATE) | (paddr == pms_pkg::A_PEND)
		| (paddr == pms_pkg::A_RTMR) | (paddr == pms_pkg::A_CAL);
	wire hit = hit_fix | in_ton | in_toff | in_dep | in_cmap;
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0;
		case (1'b1)
			paddr == pms_pkg::A_CTRL:  rd = {24'h0, ctrl_r};
			paddr == pms_pkg::A_MIN:   rd = {24'h0, min_r};
			paddr == pms_pkg::A_STATE: rd = {19'h0, mode_r, on_r};
			paddr == pms_pkg::A_PEND:  rd = {24'h0, pend_r};
			paddr == pms_pkg::A_RTMR:  rd = {24'h0, rtmr_r};
			paddr == pms_pkg::A_CAL:   rd = {16'h0, cal_r};
			in_ton:  rd = {24'h0, ton_r[idx[2:0]]};
			in_toff: rd = {24'h0, toff_r[idx[2:0]]};
			in_dep:  rd = {24'h0, dep_r[idx[2:0]]};
			in_cmap: rd = {24'h0, cmap_r[idx[1:0]]};
			default: rd = 32'h0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			prdata  <= (psel & ~penable & ~pwrite) ? rd : 32'h0;
		end
	end
	wire wr_ok = wr & pready;

	// software registers; pull-downs enabled after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 8'h0;
			min_r  <= pms_pkg::MIN_RST;
			rtmr_r <= '0;
			save_r <= 8'h0;
			for (int i = 0; i < N; i++) begin
				ton_r[i]  <= '0;
				toff_r[i] <= '0;
				dep_r[i]  <= '0;
			end
			for (int i = 0; i < pms_pkg::NCLK; i++)
				cmap_r[i] <= '0;
		end else if (mode_r == pms_pkg::PM_SHUT) begin
			// powered off: software sees a fresh part on return
			ctrl_r <= 8'h0;
			min_r  <= pms_pkg::MIN_RST;
			rtmr_r <= '0;
			save_r <= 8'h0;
			for (int i = 0; i < N; i++) begin
				ton_r[i]  <= '0;
				toff_r[i] <= '0;
				dep_r[i]  <= '0;
			end
			for (int i = 0; i < pms_pkg::NCLK; i++)
				cmap_r[i] <= '0;
		end else begin
			if (mode_r == pms_pkg::PM_SAVE)
				save_r <= ctrl_r; // retention copy
			if (mode_r == pms_pkg::PM_DEEP && wake) begin
				ctrl_r <= save_r & ~(8'h1 << pms_pkg::C_DEEP);
			end else if (wr_ok) begin
				if (paddr == pms_pkg::A_CTRL) ctrl_r <= pwdata[7:0];
				if (paddr == pms_pkg::A_MIN)  min_r  <= pwdata[N-1:0];
				if (paddr == pms_pkg::A_RTMR) rtmr_r <= pwdata[N-1:0];
				if (in_ton)  ton_r[idx[2:0]]  <= pwdata[W-1:0];
				if (in_toff) toff_r[idx[2:0]] <= pwdata[W-1:0];
				if (in_dep)  dep_r[idx[2:0]]  <= pwdata[N-1:0];
				if (in_cmap) cmap_r[idx[1:0]] <= pwdata[N-1:0];
			end
		end
	end

	// control outputs from pins, mode and ctrl, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= '0;
			ctl.pd_wlan_en <= 1'b1;
			ctl.pd_bt_en   <= 1'b1;
			resource_on_flag <= '0;
		end else begin
			ctl.reg_en      <= any_pin;
			ctl.wlan_rst_n  <= s2_r.wlan_pin
				& (mode_r != pms_pkg::PM_SHUT);
			ctl.pd_wlan_en  <= ~ctrl_r[pms_pkg::C_PD_OFF];
			ctl.pd_bt_en    <= ~ctrl_r[pms_pkg::C_PD_OFF];
			ctl.pll_clk_en  <= (mode_r == pms_pkg::PM_ACTIVE);
			ctl.xtal_clk_en <= (mode_r == pms_pkg::PM_ACTIVE);
			ctl.ldo_bypass  <= ctrl_r[pms_pkg::C_BYPASS]
				& (mode_r == pms_pkg::PM_DEEP);
			ctl.outs_oe     <= (mode_r != pms_pkg::PM_SHUT);
			ctl.ins_en      <= (mode_r != pms_pkg::PM_SHUT);
			ctl.ret_save    <= (mode_r == pms_pkg::PM_SAVE);
			ctl.ret_restore <= (mode_r == pms_pkg::PM_DEEP) & wake;
			resource_on_flag <= on_r & ~pend_r;
		end
	end

	// checks
	a_timer_zero_settled: assert property (@(posedge pclk)
		disable iff (!presetn) !pend_r[0] |-> tmr_r[0] == '0)
		else $error("timer nonzero while settled");
	a_reg_en_or: assert property (@(posedge pclk)
		disable iff (!presetn) ctl.reg_en == $past(any_pin))
		else $error("regulator enable not pin OR");
	a_wlan_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!s2_r.wlan_pin |=> !ctl.wlan_rst_n)
		else $error("wlan out of reset while pin low");
	a_shut_tristate: assert property (@(posedge pclk)
		disable iff (!presetn) mode_r == pms_pkg::PM_SHUT |=> !ctl.outs_oe)
		else $error("outputs driven in shutdown");
	a_doze_clocks: assert property (@(posedge pclk) disable iff (!presetn)
		mode_r == pms_pkg::PM_DOZE |=> !ctl.pll_clk_en && !ctl.xtal_clk_en)
		else $error("main clocks on in doze");
	a_zero_on_delay: assert property (@(posedge pclk) disable iff (!presetn)
		tick_r && !pend_r[0] && !on_r[0] && need_r[0] && ton_r[0] == '0
		&& dep_r[0] == '0 && mode_r != pms_pkg::PM_SHUT
		|=> on_r[0] && !pend_r[0])
		else $error("zero delay not immediate");
	a_timer_end: assert property (@(posedge pclk) disable iff (!presetn)
		tick_r && pend_r[0] && tmr_r[0] == W'(1) && mode_r != pms_pkg::PM_SHUT
		|=> !pend_r[0] && on_r[0] != $past(on_r[0]))
		else $error("timer end did not toggle");
	a_need_union: assert property (@(posedge pclk) disable iff (!presetn)
		tick_r |=> (need_r & $past(min_r)) == $past(min_r))
		else $error("minimum mask missing from need");

	// deep sleep steps: copy taken, then wake restores it
	sequence s_save_step;
		mode_r == pms_pkg::PM_SAVE;
	endsequence
	sequence s_deep_wake;
		mode_r == pms_pkg::PM_DEEP && wake && any_pin;
	endsequence
	a_retention_save: assert property (@(posedge pclk)
		disable iff (!presetn) s_save_step
		|=> ctl.ret_save && save_r == $past(ctrl_r)
		&& mode_r == pms_pkg::PM_DEEP)
		else $error("retention copy not taken");
	a_deep_wake: assert property (@(posedge pclk)
		disable iff (!presetn) s_deep_wake
		|=> ctl.ret_restore && mode_r == pms_pkg::PM_ACTIVE
		&& !ctrl_r[pms_pkg::C_DEEP])
		else $error("wake did not restore state");
	a_deep_bypass: assert property (@(posedge pclk)
		disable iff (!presetn) mode_r == pms_pkg::PM_DEEP
		&& ctrl_r[pms_pkg::C_BYPASS] |=> ctl.ldo_bypass)
		else $error("regulator bypass missing");
	a_shut_forgets: assert property (@(posedge pclk)
		disable iff (!presetn) mode_r == pms_pkg::PM_SHUT
		|=> ctrl_r == 8'h0 && min_r == pms_pkg::MIN_RST && on_r == '0)
		else $error("state kept through shutdown");
endmodule
